// file: hdl/rss_sequencer.sv
`include "rss_regs.svh"

module rss_sequencer #(
  parameter int POWERUP_TIMER_CYCLES = `RSS_POWERUP_TIMER_CYCLES,
  parameter int TBOR_CYCLES = `RSS_TBOR_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog detectors and pins
  input wire logic vdd_ok,
  input wire logic brownout_detect,
  input wire logic master_clear_n,
  input wire logic osc_input_pin,
  // Core side
  input wire logic sleep_wake,
  output logic core_reset_n,
  output logic wake_stall
);
  import rss_pkg::*;

  // Terminal counts; every counter starts from zero
  localparam logic [23:0] POWERUP_TIMER_LAST = 24'(POWERUP_TIMER_CYCLES - 1);
  localparam logic [23:0] TBOR_LAST = 24'(TBOR_CYCLES - 1);
  localparam logic [10:0] OST_LAST = 11'(`RSS_OST_CYCLES - 1);

  // Whole sequencer state and its next value
  rss_regs_t r_ff;
  rss_regs_t nxt_r;

  // Decoded views of the state and the bus
  logic vdd_good;
  logic below;
  logic master_clear_n_n;
  logic osc_rise;
  logic bor_trip;
  logic crystal;
  logic access;
  logic addr_ok;
  logic [31:0] cfg_word;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  // Filtered pin levels and oscillator edge
  assign vdd_good = r_ff.filt[0];
  assign below = r_ff.filt[1];
  assign master_clear_n_n = r_ff.filt[2];

  // Oscillator edge: stages agree high while the filter is still low
  assign osc_rise = !r_ff.filt[3] && r_ff.sync2[3] && r_ff.sync3[3];

  // Mode and brown-out qualification
  assign crystal = r_ff.osc_sel != resistor_capacitor_mode;
  assign bor_trip = r_ff.bor_en && below && (r_ff.bor_cnt >= TBOR_LAST);

  // Bus decode
  assign access = psel && penable;
  assign addr_ok = (paddr == `RSS_CFG_OFFSET) ||
                   (paddr == `RSS_STAT_OFFSET);

  // Configuration word as software sees it
  always_comb begin
    cfg_word = 32'h0;
    cfg_word[`RSS_CFG_OSC_HI:`RSS_CFG_OSC_LO] = r_ff.osc_sel;
    cfg_word[`RSS_CFG_POWERUP_TIMER_EN_N] = r_ff.powerup_timer_en_n;
    cfg_word[`RSS_CFG_BOR_EN] = r_ff.bor_en;
  end

  // Status word: causes, state and the two core flags
  always_comb begin
    stat_word = 32'h0;
    stat_word[`RSS_STAT_CAUSE_MASTER_CLEAR_N:`RSS_STAT_CAUSE_POR] = r_ff.cause;
    stat_word[`RSS_STAT_STATE_HI:`RSS_STAT_STATE_LO] = r_ff.state;
    stat_word[`RSS_STAT_CORE_RUN] = r_ff.core_reset_n;
    stat_word[`RSS_STAT_WAKE_STALL] = r_ff.wake_stall;
  end

  // Read data mux, unmapped offsets read as zero
  always_comb begin
    rd_word = 32'h0;
    if (paddr == `RSS_CFG_OFFSET) begin
      rd_word = cfg_word;
    end else if (paddr == `RSS_STAT_OFFSET) begin
      rd_word = stat_word;
    end
  end

  // Next state
  always_comb begin
    nxt_r = r_ff;

    // Three-stage synchronisers, change accepted when stages two and three agree
    // Stage one may be metastable, so only stages two and three are read
    nxt_r.sync1 = {osc_input_pin, master_clear_n, brownout_detect, vdd_ok};
    nxt_r.sync2 = r_ff.sync1;
    nxt_r.sync3 = r_ff.sync2;
    for (int i = 0; i < 4; i++) begin
      if (r_ff.sync2[i] == r_ff.sync3[i]) begin
        nxt_r.filt[i] = r_ff.sync3[i];
      end
    end

    // Brown-out qualifying counter, short dips clear it
    // It saturates, so a long dip cannot wrap back to zero
    if (r_ff.bor_en && below) begin
      if (r_ff.bor_cnt < TBOR_LAST) begin
        nxt_r.bor_cnt = r_ff.bor_cnt + 24'h1;
      end
    end else begin
      nxt_r.bor_cnt = 24'h0;
    end

    // Sequencer
    case (r_ff.state)
      st_por: begin
        // Only a rising supply is watched here
        if (vdd_good) begin
          nxt_r.powerup_timer_cnt = 24'h0;
          nxt_r.state = r_ff.powerup_timer_en_n ? st_ost : st_powerup_timer;
          if (r_ff.powerup_timer_en_n && !crystal) begin
            nxt_r.state = st_run;
          end
          nxt_r.ost_cnt = 11'h0;
        end
      end

      st_powerup_timer: begin
        // Timer counts pclk cycles, core held
        if (r_ff.bor_en && below) begin
          nxt_r.state = st_bor;
          nxt_r.cause[`RSS_STAT_CAUSE_BOR] = 1'b1;
        end else if (r_ff.powerup_timer_cnt == POWERUP_TIMER_LAST) begin
          // Start-up count only for a power-on cause in crystal modes
          nxt_r.ost_cnt = 11'h0;
          if (crystal && r_ff.cause[`RSS_STAT_CAUSE_POR]) begin
            nxt_r.state = st_ost;
          end else begin
            nxt_r.state = master_clear_n_n ? st_run : st_master_clear_n;
          end
        end else begin
          nxt_r.powerup_timer_cnt = r_ff.powerup_timer_cnt + 24'h1;
        end
      end

      st_ost: begin
        // Count oscillator pin cycles after the timer, or straight after power-on when the timer is disabled
        // Each filtered rising edge is one oscillator cycle
        if (osc_rise) begin
          nxt_r.ost_cnt = r_ff.ost_cnt + 11'h1;
          if (r_ff.ost_cnt == OST_LAST) begin
            nxt_r.state = master_clear_n_n ? st_run : st_master_clear_n;
          end
        end
      end

      st_bor: begin
        // Wait for supply recovery, then restart the timer, or go straight to run when it is disabled
        if (!below) begin
          nxt_r.powerup_timer_cnt = 24'h0;
          nxt_r.state = r_ff.powerup_timer_en_n ? st_run : st_powerup_timer;
        end
      end

      st_master_clear_n: begin
        // External hold, no timer on release
        if (master_clear_n_n) begin
          nxt_r.state = st_run;
        end
      end

      st_run, st_wake_ost: begin
        // Running, or running with the wake count
        // Brown-out outranks master clear
        if (bor_trip) begin
          nxt_r.state = st_bor;
          nxt_r.cause[`RSS_STAT_CAUSE_BOR] = 1'b1;
        end else if (!master_clear_n_n) begin
          nxt_r.state = st_master_clear_n;
          nxt_r.cause[`RSS_STAT_CAUSE_MASTER_CLEAR_N] = 1'b1;
        end else if (r_ff.state == st_run) begin
          // Wake count only in crystal modes
          if (sleep_wake && crystal) begin
            nxt_r.state = st_wake_ost;
            nxt_r.ost_cnt = 11'h0;
          end
        end else if (osc_rise) begin
          nxt_r.ost_cnt = r_ff.ost_cnt + 11'h1;
          if (r_ff.ost_cnt == OST_LAST) begin
            nxt_r.state = st_run;
          end
        end
      end

      default: begin
        // Illegal codes restart the power-on path
        nxt_r.state = st_por;
      end
    endcase

    // Outputs follow the next state
    // so the ports change on the same edge as the state
    nxt_r.core_reset_n = (nxt_r.state == st_run) ||
                         (nxt_r.state == st_wake_ost);
    nxt_r.wake_stall = nxt_r.state == st_wake_ost;

    // APB: one wait state, write acts on the edge that sees pready
    // First access cycle answers; the cycle seen with pready commits
    if (access && !r_ff.pready) begin
      // Unmapped offsets answer with an error and change nothing
      nxt_r.pready = 1'b1;
      nxt_r.pslverr = !addr_ok;
      nxt_r.prdata = pwrite ? 32'h0 : rd_word;
    end else if (access) begin
      nxt_r.pready = 1'b0;
      nxt_r.pslverr = 1'b0;
      if (pwrite && paddr == `RSS_CFG_OFFSET) begin
        // Configuration takes effect on the committing edge
        nxt_r.osc_sel = rss_osc_mode_t'(
          pwdata[`RSS_CFG_OSC_HI:`RSS_CFG_OSC_LO]);
        nxt_r.powerup_timer_en_n = pwdata[`RSS_CFG_POWERUP_TIMER_EN_N];
        nxt_r.bor_en = pwdata[`RSS_CFG_BOR_EN];
      end else if (pwrite && paddr == `RSS_STAT_OFFSET) begin
        // Write one to clear; a cause set this cycle is kept
        nxt_r.cause = (r_ff.cause & ~pwdata[2:0]) |
                      (nxt_r.cause & ~r_ff.cause);
      end
    end else begin
      nxt_r.pready = 1'b0;
      nxt_r.pslverr = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '{
        // Filters idle at supply low, no brown-out, clear released
        sync1: 4'h4,
        sync2: 4'h4,
        sync3: 4'h4,
        filt: 4'h4,
        // Sequencer waits for the supply at power-on
        state: st_por,
        powerup_timer_cnt: 24'h0,
        bor_cnt: 24'h0,
        ost_cnt: 11'h0,
        // Configuration defaults
        osc_sel: rss_osc_mode_t'(`RSS_CFG_OSC_RESET),
        powerup_timer_en_n: `RSS_CFG_POWERUP_TIMER_EN_N_RESET,
        bor_en: `RSS_CFG_BOR_EN_RESET,
        // Power-on is the recorded cause
        cause: 3'h1,
        // Core held, bus idle
        core_reset_n: 1'b0,
        wake_stall: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0
      };
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Bus answer straight from the state register
  assign prdata = r_ff.prdata;
  assign pready = r_ff.pready;
  assign pslverr = r_ff.pslverr;

  // Core reset and wake flag straight from the state register
  assign core_reset_n = r_ff.core_reset_n;
  assign wake_stall = r_ff.wake_stall;

endmodule

// file: inc/rss_regs.svh
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// Register byte offsets
`define RSS_CFG_OFFSET 12'h000
`define RSS_STAT_OFFSET 12'h004

// Configuration register fields
`define RSS_CFG_OSC_LO 0
`define RSS_CFG_OSC_HI 1
`define RSS_CFG_POWERUP_TIMER_EN_N 2
`define RSS_CFG_BOR_EN 3

// Status register fields
`define RSS_STAT_CAUSE_POR 0
`define RSS_STAT_CAUSE_BOR 1
`define RSS_STAT_CAUSE_MASTER_CLEAR_N 2
`define RSS_STAT_STATE_LO 4
`define RSS_STAT_STATE_HI 6
`define RSS_STAT_CORE_RUN 8
`define RSS_STAT_WAKE_STALL 9

// Reset values
`define RSS_CFG_OSC_RESET 2'h1
`define RSS_CFG_POWERUP_TIMER_EN_N_RESET 1'h0
`define RSS_CFG_BOR_EN_RESET 1'h1

// Timing
`define RSS_CLK_MHZ 200
`define RSS_POWERUP_TIMER_MS 72
`define RSS_POWERUP_TIMER_CYCLES (`RSS_POWERUP_TIMER_MS * 1000 * `RSS_CLK_MHZ)
`define RSS_TBOR_US 100
`define RSS_TBOR_CYCLES (`RSS_TBOR_US * `RSS_CLK_MHZ)
`define RSS_OST_CYCLES 1024

`endif

// file: inc/rss_pkg.sv
package rss_pkg;

  // Oscillator mode selection
  typedef enum logic [1:0] {
    low_power_crystal_mode = 2'h0,
    crystal_resonator_mode = 2'h1,
    high_speed_crystal_mode = 2'h2,
    resistor_capacitor_mode = 2'h3
  } rss_osc_mode_t;

  // Sequencer states
  typedef enum logic [2:0] {
    st_por,
    st_powerup_timer,
    st_ost,
    st_bor,
    st_master_clear_n,
    st_run,
    st_wake_ost
  } rss_state_t;

  // All state of the sequencer
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] filt;
    rss_state_t state;
    logic [23:0] powerup_timer_cnt;
    logic [23:0] bor_cnt;
    logic [10:0] ost_cnt;
    rss_osc_mode_t osc_sel;
    logic powerup_timer_en_n;
    logic bor_en;
    logic [2:0] cause;
    logic core_reset_n;
    logic wake_stall;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rss_regs_t;

endpackage

// file: bench/rss_sequencer_monitor.sv
module rss_sequencer_monitor #(
  parameter int POWERUP_TIMER_CYCLES = 50
) (
  // Clock, reset and APB
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Pins and core side
  input wire logic vdd_ok, brownout_detect, master_clear_n, osc_input_pin,
  input wire logic sleep_wake, core_reset_n, wake_stall
);
  logic [3:0] cfg_ff;
  logic [31:0] low_ff, osc_ff;
  logic first_ff, osc_d_ff;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Config mirror; cycles and pin rises up to first release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= 4'h9;
      low_ff <= '0;
      osc_ff <= '0;
      osc_d_ff <= 1'b0;
      first_ff <= 1'b1;
    end else begin
      if (psel && penable && pready && pwrite && paddr == 12'h000)
        cfg_ff <= pwdata[3:0];
      low_ff <= low_ff + {31'h0, first_ff};
      osc_ff <= osc_ff + {31'h0, first_ff & osc_input_pin & ~osc_d_ff};
      osc_d_ff <= osc_input_pin;
      first_ff <= first_ff & ~core_reset_n;
    end
  end
  // Bus timing and responses
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_error_map: assert property (pready |-> pslverr == ((paddr & 12'hffb) != 0))
    else $error("wrong error response");
  a_cfg_read: assert property
    (pready && !pwrite && paddr == 12'h000 |-> prdata[3:0] == cfg_ff)
    else $error("configuration read back wrong");
  // Release order after power-on and wake
  a_powerup_timer_hold: assert property
    ($rose(core_reset_n) && first_ff |-> low_ff >= POWERUP_TIMER_CYCLES)
    else $error("core released before timer expiry");
  a_ost_count: assert property
    ($rose(core_reset_n) && first_ff && cfg_ff[1:0] != 2'h3 |-> osc_ff >= 1024)
    else $error("core released before start-up count");
  a_wake_stall: assert property
    (sleep_wake && core_reset_n && cfg_ff[1:0] != 2'h3 |=> wake_stall)
    else $error("wake did not stall");
  // Main scenarios
  cover property ($rose(core_reset_n));
  cover property ($fell(wake_stall));
  cover property (pready && pslverr);
endmodule

bind rss_sequencer rss_sequencer_monitor #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES)) i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .vdd_ok(vdd_ok),
  .brownout_detect(brownout_detect), .master_clear_n(master_clear_n),
  .osc_input_pin(osc_input_pin), .sleep_wake(sleep_wake),
  .core_reset_n(core_reset_n), .wake_stall(wake_stall));

// file: bench/rss_sequencer_bench.sv
module rss_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 50;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, core_reset_n, wake_stall, sleep_wake = 0;
  logic vdd_ok = 0, brownout_detect = 0, master_clear_n = 1, osc_input_pin = 0;
  int fails = 0, compares = 0, n;
  // Clock; oscillator pin at one eighth of it
  always #2.5 pclk = ~pclk;
  always #20 osc_input_pin <= ~osc_input_pin;
  rss_sequencer #(.POWERUP_TIMER_CYCLES(PW), .TBOR_CYCLES(8)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vdd_ok(vdd_ok),
    .brownout_detect(brownout_detect), .master_clear_n(master_clear_n),
    .osc_input_pin(osc_input_pin), .sleep_wake(sleep_wake),
    .core_reset_n(core_reset_n), .wake_stall(wake_stall));
  task ck(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) $display("BAD %0t %h %h", $time, s, x);
    fails += (s !== x);
  endtask
  task results;
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // APB transfer; read data compared with d, error with the map
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(negedge pclk); while (pready !== 1'b1);
    ck(pslverr, (a & 12'hffb) != 0);
    if (!w) ck(prdata, d);
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // Wait for core reset or wake stall to reach a level
  task wt(input bit s, input logic l);
    for (n = 0; n < 20000; n++) begin
      @(negedge pclk);
      if ((s ? wake_stall : core_reset_n) === l) break;
    end
    @(posedge pclk);
  endtask
  task bo(input int len);
    brownout_detect <= 1;
    repeat (len) @(posedge pclk);
    brownout_detect <= 0;
  endtask
  task wake;
    sleep_wake <= 1;
    @(posedge pclk);
    sleep_wake <= 0;
    @(posedge pclk);
  endtask
  initial begin
    #400000;
    fails++;
    results();
  end
  // Power-on, registers, wake, brown-out and timer skip
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (20) @(posedge pclk);
    ck(core_reset_n, 0);
    vdd_ok <= 1;
    wt(0, 1);
    ck(n > 8000, 1);
    apb(0, 12'h000, 32'h9);
    apb(0, 12'h004, 32'h151);
    apb(0, 12'h008, 32'h0);
    wake();
    ck(wake_stall, 1);
    wt(1, 0);
    ck(n > 8000 && core_reset_n, 1);
    apb(1, 12'h004, 32'h7);
    bo(40);
    ck(core_reset_n, 0);
    repeat (20) @(posedge pclk);
    bo(20);
    wt(0, 1);
    ck(n >= PW && n < 200, 1);
    apb(1, 12'h000, 32'h1);
    bo(40);
    ck(core_reset_n, 1);
    apb(1, 12'h000, 32'hf);
    bo(40);
    wt(0, 1);
    ck(n < PW, 1);
    wake();
    ck(wake_stall, 0);
    vdd_ok <= 0;
    repeat (10) @(posedge pclk);
    ck(core_reset_n, 1);
    master_clear_n <= 0;
    repeat (10) @(posedge pclk);
    ck(core_reset_n, 0);
    apb(0, 12'h004, 32'h46);
    master_clear_n <= 1;
    wt(0, 1);
    ck(n < 20, 1);
    results();
  end
endmodule
